/* File: rtl/arf_defs.vh */
// Purpose: Constants for the converter result and threshold block
// Assumes: 32-bit AXI4-Lite register window, 12-bit byte address
// Notes:   Offsets are byte addresses inside the block window
`ifndef ARF_DEFS_VH
`define ARF_DEFS_VH
// Register byte offsets
`define ARF_OFF_CTRL     12'h000
`define ARF_OFF_CHSEL    12'h004
`define ARF_OFF_RATE     12'h008
`define ARF_OFF_SEQ      12'h00C
`define ARF_OFF_CMP      12'h010
`define ARF_OFF_IBUF     12'h014
`define ARF_OFF_ISEL     12'h018
`define ARF_OFF_STAT     12'h01C
`define ARF_OFF_RES      12'h100
`define ARF_RES_IDX_MSB  6
`define ARF_RES_IDX_LSB  2
`define ARF_RES_SEL_MSB  11
`define ARF_RES_SEL_LSB  7
`define ARF_RES_SEL      5'h02
// Reset values
`define ARF_CTRL_RST     32'h0000_0280
`define ARF_ZERO         32'h0000_0000
// Converter control mode field
`define ARF_MODE_MSB     2
`define ARF_MODE_LSB     0
`define ARF_MODE_SINGLE  3'h2
// Channel select fields
`define ARF_CHSEL_MSB    12
`define ARF_POS_MSB      4
`define ARF_CH_TEMP      5'h16
`define ARF_CH_AVDD      5'h14
`define ARF_CH_IOVDD     5'h15
// Rate register fields
`define ARF_RATE_MSB     9
`define ARF_ACQ_MSB      25
`define ARF_ACQ_LSB      16
`define ARF_SLOW_SPS     80000
`define ARF_CORE_HZ      20000000
// Sequencer control fields
`define ARF_SEQ_EN_MSB   31
`define ARF_SEQ_EN_LSB   30
`define ARF_SEQ_RESTART  31
`define ARF_SEQ_ON       2'h3
// Result layout
`define ARF_RES_MSB      27
`define ARF_SE_LSB       12
`define ARF_DIF_LSB      13
`define ARF_FRESH        0
// Comparator fields
`define ARF_CMP_CHAN     5'h04
`define ARF_THR_MSB      17
`define ARF_THR_LSB      2
`define ARF_CMP_DIR      1
// Interrupt select fields
`define ARF_ISEL_IRQ1    2
`define ARF_ISEL_IRQ0    10
// Buffer control fields
`define ARF_BYP_MSB      1
`define ARF_BYP_LSB      0
`define ARF_PD_MSB       3
`define ARF_PD_LSB       2
// Bus answers
`define ARF_RESP_OKAY    2'h0
`define ARF_RESP_SLVERR  2'h2
`endif

/* File: rtl/arf_top.v */
// Purpose: Result formatting, slow-channel rate takeover, buffer
//          switch control and edge threshold comparator for a
//          16-bit converter, reached over AXI4-Lite
// Assumes: Converter core strobes on aclk, one result per conv_done
// Notes:   Core delivers raw offset-binary codes in both modes
//
// Contract
// R01 - Single-ended results coded straight binary
// R02 - Single-ended result placed at bits 27:12
// R03 - Differential results coded twos complement
// R04 - Differential result aligned at bits 27:13
// R05 - Each conversion stores a result word
// R06 - Slow channel selection forces 80 kSPS rate
// R07 - Enabled sequencer leaves rate register unchanged
// R08 - Channel select bits 12:0 route input
// R09 - Sequencer bit 31 restarts from first channel
// R10 - Comparator watches channel four only
// R11 - Threshold bits 17:2 against data 27:12
// R12 - Direction bit 1 picks rising or falling
// R13 - Rising sense fires once on crossing above
// R14 - Falling sense fires once on crossing below
// R15 - Event to line1 by bit2, line0 bit10
// R16 - Buffer bypass bits 1:0, power-down 3:2
// R17 - Control, select, rate, start conversion order
// R18 - Rate bits 9:0, acquisition bits 25:16
// R19 - Per-channel result register, positive channel
// R20 - Crossed state cleared by reset, direction
`include "arf_defs.vh"
`default_nettype none
module arf_top #(
	parameter NCH = 32
) (
	input  wire        aclk,          // System clock
	input  wire        aresetn,       // Synchronous reset, low
	input  wire [11:0] s_axi_awaddr,  // Write address
	input  wire        s_axi_awvalid, // Write address valid
	output wire        s_axi_awready, // Write address ready
	input  wire [31:0] s_axi_wdata,   // Write data
	input  wire [3:0]  s_axi_wstrb,   // Write byte enables
	input  wire        s_axi_wvalid,  // Write data valid
	output wire        s_axi_wready,  // Write data ready
	output reg  [1:0]  s_axi_bresp,   // Write response
	output reg         s_axi_bvalid,  // Write response valid
	input  wire        s_axi_bready,  // Write response ready
	input  wire [11:0] s_axi_araddr,  // Read address
	input  wire        s_axi_arvalid, // Read address valid
	output wire        s_axi_arready, // Read address ready
	output reg  [31:0] s_axi_rdata,   // Read data
	output reg  [1:0]  s_axi_rresp,   // Read response
	output reg         s_axi_rvalid,  // Read data valid
	input  wire        s_axi_rready,  // Read data ready
	input  wire        conv_done,     // Core result strobe
	input  wire [15:0] conv_result,   // Core raw code
	input  wire        conv_diff,     // Result is differential
	input  wire [4:0]  conv_chan,     // Positive channel of result
	output reg         conv_start,    // Single conversion pulse
	output wire [31:0] converter_control, // Control word to core
	output wire [12:0] channel_select,    // Mux routing
	output wire [9:0]  rate_code,         // Update rate code
	output wire [9:0]  acq_code,          // Acquisition time code
	output wire        seq_enable,        // Sequencer running
	output reg         seq_restart,       // Restart from first chan
	output wire [1:0]  buffer_bypass_switches, // Bypass switches
	output wire [1:0]  buffer_power_down,      // Buffer power-down
	output reg         lv_irq0,       // Die interrupt line 0 pulse
	output reg         lv_irq1        // Die interrupt line 1 pulse
);

	// Divide in integer width first, then keep the rate field bits
	localparam integer SLOW_DIV = `ARF_CORE_HZ / `ARF_SLOW_SPS;
	localparam [9:0] SLOW_CODE = SLOW_DIV[9:0];

	reg  [31:0] ctrl_q;
	reg  [31:0] chsel_q;
	reg  [31:0] rate_q;
	reg  [31:0] seq_q;
	reg  [31:0] cmp_q;
	reg  [31:0] ibuf_q;
	reg  [31:0] isel_q;
	reg  [11:0] awaddr_q;
	reg         aw_got_q;
	reg  [31:0] wdata_q;
	reg  [3:0]  wstrb_q;
	reg         w_got_q;
	reg         above_q;
	reg         below_q;
	reg         cmp_hit_q;
	wire [31:0] res_word [0:NCH-1];
	wire [NCH-1:0] rd_clr;
	wire [31:0] wmask;
	wire [31:0] wnew;
	wire        wr_go;
	wire        rd_go;
	wire        res_wr_hit;
	wire        res_rd_hit;
	wire [4:0]  rd_idx;
	reg  [31:0] rd_val;
	reg         rd_ok;
	reg         wr_ok;
	wire [15:0] raw_tc;
	wire [31:0] new_word;
	wire [4:0]  new_pos;
	wire [15:0] ch4_val;
	wire [15:0] thr;
	wire        is_above;
	wire        is_below;
	wire        cmp_evt;
	wire        slow_sel;
	wire        seq_on;

	// Address and data taken separately; held until response done
	assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;

	assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
		{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

	// Pending write merged with old contents per byte lane
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nv;
		input [31:0] m;
		begin
			merge = (old & ~m) | (nv & m);
		end
	endfunction

	assign wnew = wdata_q;

	// Capture write address and data channels
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q  <= `ARF_ZERO;
			wstrb_q  <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `ARF_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `ARF_RESP_OKAY
					: `ARF_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Result words are read only; only control offsets accept writes
	always @* begin
		case (awaddr_q)
		`ARF_OFF_CTRL, `ARF_OFF_CHSEL, `ARF_OFF_RATE, `ARF_OFF_SEQ,
		`ARF_OFF_CMP, `ARF_OFF_IBUF, `ARF_OFF_ISEL: begin
			wr_ok = 1'b1;
		end
		default: begin
			wr_ok = 1'b0;
		end
		endcase
	end

	assign seq_on = (seq_q[`ARF_SEQ_EN_MSB:`ARF_SEQ_EN_LSB]
		== `ARF_SEQ_ON);
	// Positive select of the word being written
	assign slow_sel = (wnew[`ARF_POS_MSB:0] == `ARF_CH_TEMP) ||
		(wnew[`ARF_POS_MSB:0] == `ARF_CH_AVDD) ||
		(wnew[`ARF_POS_MSB:0] == `ARF_CH_IOVDD);

	// Control register file; rate takeover rides on channel writes
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q  <= `ARF_CTRL_RST;
			chsel_q <= `ARF_ZERO;
			rate_q  <= `ARF_ZERO;
			seq_q   <= `ARF_ZERO;
			cmp_q   <= `ARF_ZERO;
			ibuf_q  <= `ARF_ZERO;
			isel_q  <= `ARF_ZERO;
			conv_start  <= 1'b0;
			seq_restart <= 1'b0;
		end else begin
			conv_start  <= 1'b0;
			seq_restart <= 1'b0;
			if (wr_go) begin
				case (awaddr_q)
				`ARF_OFF_CTRL: begin
					ctrl_q <= merge(ctrl_q, wnew, wmask);
					// Mode write of single starts one conversion
					conv_start <= wmask[`ARF_MODE_LSB] &&
						(wnew[`ARF_MODE_MSB:`ARF_MODE_LSB] ==
						`ARF_MODE_SINGLE); // R17
				end
				`ARF_OFF_CHSEL: begin
					chsel_q <= merge(chsel_q, wnew, wmask); // R08
					// Slow internal channels need the long rate;
					// a running sequencer keeps its own setting
					if (wmask[0] && slow_sel && !seq_on) begin // R07
						rate_q[`ARF_RATE_MSB:0] <= SLOW_CODE; // R06
					end
				end
				`ARF_OFF_RATE: begin
					rate_q <= merge(rate_q, wnew, wmask); // R18
				end
				`ARF_OFF_SEQ: begin
					seq_q <= merge(seq_q, wnew, wmask);
					// Restart request is a pulse to the sequencer
					seq_restart <= wmask[`ARF_SEQ_RESTART] &&
						wnew[`ARF_SEQ_RESTART]; // R09
				end
				`ARF_OFF_CMP: begin
					cmp_q <= merge(cmp_q, wnew, wmask);
				end
				`ARF_OFF_IBUF: begin
					ibuf_q <= merge(ibuf_q, wnew, wmask);
				end
				`ARF_OFF_ISEL: begin
					isel_q <= merge(isel_q, wnew, wmask);
				end
				default: begin
					ctrl_q <= ctrl_q;
				end
				endcase
			end
		end
	end

	assign converter_control = ctrl_q;
	assign channel_select    = chsel_q[`ARF_CHSEL_MSB:0]; // R08
	assign rate_code = rate_q[`ARF_RATE_MSB:0]; // R18
	assign acq_code  = rate_q[`ARF_ACQ_MSB:`ARF_ACQ_LSB]; // R18
	assign seq_enable = seq_on;
	assign buffer_bypass_switches =
		ibuf_q[`ARF_BYP_MSB:`ARF_BYP_LSB]; // R16
	assign buffer_power_down = ibuf_q[`ARF_PD_MSB:`ARF_PD_LSB]; // R16

	// Offset binary to twos complement is a flip of the sign bit
	assign raw_tc = {~conv_result[15], conv_result[14:0]}; // R03
	// Differential keeps 15 bits at 27:13, sign-extended above
	assign new_word = conv_diff ?
		{{4{raw_tc[15]}}, raw_tc[15:1], 12'h000, 1'b1} // R04
		: {4'h0, conv_result, 11'h000, 1'b1}; // R01 R02
	assign new_pos = conv_chan;

	assign res_wr_hit = (awaddr_q[`ARF_RES_SEL_MSB:`ARF_RES_SEL_LSB]
		== `ARF_RES_SEL);
	assign res_rd_hit = (s_axi_araddr[`ARF_RES_SEL_MSB:`ARF_RES_SEL_LSB]
		== `ARF_RES_SEL) &&
		(s_axi_araddr[1:0] == 2'h0) &&
		({27'h0, rd_idx} < NCH);
	assign rd_idx = s_axi_araddr[`ARF_RES_IDX_MSB:`ARF_RES_IDX_LSB];

	// One result word per channel; fresh flag clears on a bus read
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi = gi + 1) begin : g_res
			reg [31:0] word_q;
			wire       hit;
			assign hit = conv_done && (new_pos == gi); // R19
			assign rd_clr[gi] = rd_go && res_rd_hit && (rd_idx == gi);
			always @(posedge aclk) begin
				if (!aresetn) begin
					word_q <= `ARF_ZERO;
				end else if (hit) begin
					// New result wins over a same-cycle read clear
					word_q <= new_word; // R05
				end else if (rd_clr[gi]) begin
					word_q[`ARF_FRESH] <= 1'b0;
				end
			end
			assign res_word[gi] = word_q;
		end
	endgenerate

	// Read decode
	always @* begin
		rd_ok  = 1'b1;
		rd_val = `ARF_ZERO;
		if (res_rd_hit) begin
			rd_val = res_word[rd_idx];
		end else begin
			case (s_axi_araddr)
			`ARF_OFF_CTRL:  rd_val = ctrl_q;
			`ARF_OFF_CHSEL: rd_val = chsel_q;
			`ARF_OFF_RATE:  rd_val = rate_q;
			`ARF_OFF_SEQ:   rd_val = seq_q;
			`ARF_OFF_CMP:   rd_val = cmp_q;
			`ARF_OFF_IBUF:  rd_val = ibuf_q;
			`ARF_OFF_ISEL:  rd_val = isel_q;
			`ARF_OFF_STAT:  rd_val = {29'h0, cmp_hit_q, below_q, above_q};
			default: begin
				rd_ok  = 1'b0;
				rd_val = `ARF_ZERO;
			end
			endcase
		end
	end

	// Read channel; data registered one cycle after acceptance
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= `ARF_ZERO;
			s_axi_rresp  <= `ARF_RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_val;
			s_axi_rresp  <= rd_ok ? `ARF_RESP_OKAY : `ARF_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Comparator sees the incoming channel four word field, same layout as stored
	assign ch4_val = new_word[`ARF_RES_MSB:`ARF_SE_LSB]; // R11
	assign thr = cmp_q[`ARF_THR_MSB:`ARF_THR_LSB]; // R11
	assign is_above = (ch4_val > thr);
	assign is_below = (ch4_val < thr);
	// Edge only: level alone would re-fire on every sample
	assign cmp_evt = conv_done && (new_pos == `ARF_CMP_CHAN) && // R10
		(cmp_q[`ARF_CMP_DIR] ? (is_above && !above_q) // R12 R13
		: (is_below && !below_q)); // R14

	// Crossed state; a write that changes direction rearms both senses
	always @(posedge aclk) begin
		if (!aresetn) begin
			above_q   <= 1'b0;
			below_q   <= 1'b0;
			cmp_hit_q <= 1'b0;
			lv_irq0   <= 1'b0;
			lv_irq1   <= 1'b0;
		end else begin
			if (wr_go && (awaddr_q == `ARF_OFF_CMP) &&
				wmask[`ARF_CMP_DIR] &&
				(wnew[`ARF_CMP_DIR] != cmp_q[`ARF_CMP_DIR])) begin
				above_q <= 1'b0; // R20
				below_q <= 1'b0; // R20
			end else if (conv_done && (new_pos == `ARF_CMP_CHAN)) begin
				above_q <= is_above;
				below_q <= is_below;
			end
			if (cmp_evt) begin
				cmp_hit_q <= 1'b1;
			end else if (rd_go && (s_axi_araddr == `ARF_OFF_STAT)) begin
				cmp_hit_q <= 1'b0;
			end
			lv_irq1 <= cmp_evt && isel_q[`ARF_ISEL_IRQ1]; // R15
			lv_irq0 <= cmp_evt && isel_q[`ARF_ISEL_IRQ0]; // R15
		end
	end

	// Write side of result range never matches a writable offset
	wire unused_ok;
	assign unused_ok = res_wr_hit & wr_ok;

endmodule
`default_nettype wire

/* File: rtl/arf_pad.v */
`default_nettype none
`default_nettype wire

/* File: tb/arf_chk_assertions.sv */
// Purpose: Timing checks on the ports of the result block
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound to the top module from the bench top file
`default_nettype none
module arf_chk #(
	parameter int NCH = 32
) (
	input wire logic        aclk,                   // Clock
	input wire logic        aresetn,                // Reset, low
	input wire logic        s_axi_awvalid,          // Write address valid
	input wire logic        s_axi_awready,          // Write address ready
	input wire logic        s_axi_wvalid,           // Write data valid
	input wire logic        s_axi_wready,           // Write data ready
	input wire logic        s_axi_bvalid,           // Write response valid
	input wire logic        s_axi_bready,           // Write response ready
	input wire logic        s_axi_arvalid,          // Read address valid
	input wire logic        s_axi_arready,          // Read address ready
	input wire logic [31:0] s_axi_rdata,            // Read data
	input wire logic        s_axi_rvalid,           // Read data valid
	input wire logic        s_axi_rready,           // Read data ready
	input wire logic        conv_done,              // Result strobe
	input wire logic [4:0]  conv_chan,              // Result channel
	input wire logic        conv_start,             // Start pulse
	input wire logic [9:0]  rate_code,              // Rate code
	input wire logic [1:0]  buffer_bypass_switches, // Bypass switches
	input wire logic        lv_irq0,                // Interrupt line 0
	input wire logic        lv_irq1                 // Interrupt line 1
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Bus answers arrive in bounded time and stand until taken
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write answer missing");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
		|-> ##[1:2] s_axi_rvalid) else $error("read answer missing");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid) else $error("write answer dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer changed");
	bus_refuse_a: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready) else $error("ready early");
	// Events only follow a channel four result
	irq_cause_a: assert property (lv_irq0 || lv_irq1 |->
		$past(conv_done) && $past(conv_chan) == 5'h04)
		else $error("event without channel four result");
	irq_single_a: assert property (lv_irq1 |=> !lv_irq1)
		else $error("repeated event");
	start_pulse_a: assert property (conv_start |=> !conv_start)
		else $error("start not a pulse");
	// Register outputs move only with a completed write
	rate_cause_a: assert property ($changed(rate_code)
		|-> $rose(s_axi_bvalid)) else $error("rate moved alone");
	byp_cause_a: assert property ($changed(buffer_bypass_switches)
		|-> $rose(s_axi_bvalid)) else $error("bypass moved alone");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (lv_irq1);
	cover property (conv_done && conv_chan == 5'h04);
endmodule
`default_nettype wire

/* File: tb/arf_core_model.sv */
// Purpose: Converter core stand-in that answers start requests
// Assumes: One clock shared with the block
// Notes:   Code lines toggle between strobes so a stale code never passes
`default_nettype none
module arf_core_model (
	input  wire logic        aclk,       // Clock
	input  wire logic        go,         // Bench-issued start
	input  wire logic        conv_start, // Block-issued start
	input  wire logic [7:0]  dly,        // Answer delay in cycles
	input  wire logic [15:0] code,       // Code to deliver
	output var  logic        conv_done,  // Result strobe
	output var  logic [15:0] conv_result // Raw offset-binary code
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = -1;
	initial conv_done = 1'b0;
	initial conv_result = 16'h0000;
	// One strobe per start; a new start restarts the wait
	always @(posedge aclk) begin
		conv_done <= 1'b0;
		conv_result <= ~conv_result;
		if (cnt == 0) begin
			conv_done <= 1'b1;
			conv_result <= code;
		end
		if (cnt >= 0)
			cnt <= cnt - 1;
		if (go || conv_start)
			cnt <= dly;
	end
endmodule
`default_nettype wire

/* File: tb/test_adc_result_format_and_threshold.sv */
// Purpose: Self-checking bench for the converter result block
// Assumes: Core model answers every start; registers over AXI4-Lite
// Notes:   Expected words and event counts come from the bench model
`include "arf_defs.vh"
`default_nettype none
module test_adc_result_format_and_threshold;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        go, diff, bvalid, awready, wready, arready, rvalid, done;
	logic        conv_start, seq_enable, seq_restart, irq0, irq1;
	logic [1:0]  bresp, rresp, byp, pd;
	logic [4:0]  chan;
	logic [7:0]  dly;
	logic [9:0]  rate_code, acq_code;
	logic [11:0] awaddr, araddr;
	logic [12:0] channel_select;
	logic [15:0] code, result, thr;
	logic [31:0] wdata, rdata, isel, ctl, v;
	logic [4:0]  slow [3] = '{5'h16, 5'h14, 5'h15};
	logic [15:0] cseq [7] = '{16'h9000, 16'hA000, 16'h8000, 16'h9000,
		16'h7000, 16'h6000, 16'h9000};
	int          bad_count, num_checks, cyc, n_start, n_rst, n0, n1;
	int          e0, e1, es, er;
	bit          dir, above, below;
	arf_top u_arf_top (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv_done(done),
		.conv_result(result), .conv_diff(diff), .conv_chan(chan),
		.conv_start(conv_start), .converter_control(ctl),
		.channel_select(channel_select), .rate_code(rate_code),
		.acq_code(acq_code), .seq_enable(seq_enable),
		.seq_restart(seq_restart), .buffer_bypass_switches(byp),
		.buffer_power_down(pd), .lv_irq0(irq0), .lv_irq1(irq1));
	arf_core_model u_arf_core_model (.aclk(aclk), .go(go),
		.conv_start(conv_start), .dly(dly), .code(code),
		.conv_done(done), .conv_result(result));
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	// Pulse counters and the hang guard
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		n_start <= n_start + int'(conv_start);
		n_rst <= n_rst + int'(seq_restart);
		n0 <= n0 + int'(irq0);
		n1 <= n1 + int'(irq1);
		if (cyc == 20000) begin
			bad_count++;
			results();
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Address and data leave independently once each is taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] e);
		bit ga, gw;
		ga = 0;
		gw = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (ga && gw && bvalid === 1'b1)
				break;
			if (!ga && awready === 1'b1) begin
				ga = 1;
				awvalid <= 1'b0;
			end
			if (!gw && wready === 1'b1) begin
				gw = 1;
				wvalid <= 1'b0;
			end
		end
		chk("write response", bresp, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] e);
		bit g;
		g = 0;
		araddr <= a;
		arvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (g && rvalid === 1'b1)
				break;
			if (!g && arready === 1'b1) begin
				g = 1;
				arvalid <= 1'b0;
			end
		end
		chk("read data", rdata, d);
		chk("read response", rresp, e);
	endtask
	// One conversion, started by the bench or by a control write
	task automatic res(input logic [4:0] ch, input logic df,
		input logic [15:0] c, input bit kick);
		logic [31:0] w;
		bit ev;
		chan <= ch;
		diff <= df;
		code <= c;
		dly <= 8'($urandom_range(4, 9));
		if (kick) begin
			go <= 1'b1;
			@(posedge aclk);
			go <= 1'b0;
		end else begin
			es++;
			wr(`ARF_OFF_CTRL, 32'h0000_0002, `ARF_RESP_OKAY);
		end
		do
			@(posedge aclk);
		while (done !== 1'b1);
		w = df ? {{5{~c[15]}}, c[14:1], 12'h000, 1'b1}
			: {4'h0, c, 11'h000, 1'b1};
		if (ch == 5'h04) begin
			ev = dir ? w[27:12] > thr && !above : w[27:12] < thr && !below;
			above = w[27:12] > thr;
			below = w[27:12] < thr;
			e1 += int'(ev & isel[2]);
			e0 += int'(ev & isel[10]);
		end
		repeat (3) @(posedge aclk);
		chk("line 0 events", n0, e0);
		chk("line 1 events", n1, e1);
		rd(`ARF_OFF_RES | {5'h00, ch, 2'b00}, w, `ARF_RESP_OKAY);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		{awvalid, wvalid, arvalid, go, diff, dir, above, below} = '0;
		{bready, rready} = 2'b11;
		{awaddr, araddr, wdata, code, chan, thr, isel} = '0;
		dly = 8'h04;
		aresetn = 1'b0;
		void'($urandom(32'hc44c));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`ARF_OFF_CTRL, `ARF_CTRL_RST, `ARF_RESP_OKAY);
		rd(`ARF_OFF_IBUF, `ARF_ZERO, `ARF_RESP_OKAY);
		// Single conversion recipe
		wr(`ARF_OFF_CTRL, 32'h0000_0280, `ARF_RESP_OKAY);
		wr(`ARF_OFF_CHSEL, 32'h0000_1100, `ARF_RESP_OKAY);
		wr(`ARF_OFF_RATE, 32'h000A_00C8, `ARF_RESP_OKAY);
		chk("rate", rate_code, 32'h0000_00C8);
		chk("acquisition", acq_code, 32'h0000_000A);
		res(5'h00, 1'b0, 16'($urandom), 1'b0);
		chk("starts", n_start, es);
		// Both codings, random and extreme codes
		repeat (8) res(5'($urandom), 1'($urandom), 16'($urandom), 1);
		res(5'h02, 1'b1, 16'h0000, 1'b1);
		res(5'h06, 1'b1, 16'hFFFF, 1'b1);
		res(5'h1F, 1'b0, 16'hFFFF, 1'b1);
		// Slow channels take the rate over unless sequencing
		foreach (slow[i]) begin
			wr(`ARF_OFF_RATE, 32'h000A_00C8, `ARF_RESP_OKAY);
			wr(`ARF_OFF_CHSEL, 32'h1100 | slow[i], `ARF_RESP_OKAY);
			chk("select", channel_select, 32'h1100 | slow[i]);
			chk("slow rate", rate_code, 32'd250);
			chk("acquisition", acq_code, 32'h0000_000A);
		end
		wr(`ARF_OFF_SEQ, 32'hC000_0000, `ARF_RESP_OKAY);
		wr(`ARF_OFF_RATE, 32'h000A_00C8, `ARF_RESP_OKAY);
		wr(`ARF_OFF_CHSEL, 32'h0000_1116, `ARF_RESP_OKAY);
		chk("sequencing", seq_enable, 32'h1);
		chk("kept rate", rate_code, 32'h0000_00C8);
		wr(`ARF_OFF_SEQ, `ARF_ZERO, `ARF_RESP_OKAY);
		wr(`ARF_OFF_SEQ, 32'h8000_0000, `ARF_RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk("restarts", n_rst, 32'd2);
		chk("sequencing", seq_enable, 32'h0);
		// Buffer switches follow their fields
		repeat (2) begin
			v = {28'h0, 4'($urandom)};
			wr(`ARF_OFF_IBUF, v, `ARF_RESP_OKAY);
			chk("bypass", byp, v[1:0]);
			chk("power down", pd, v[3:2]);
			rd(`ARF_OFF_IBUF, v, `ARF_RESP_OKAY);
		end
		// Comparator in both senses, each fresh after a turn
		isel = 32'h0000_0404;
		for (int d = 1; d >= 0; d--) begin
			wr(`ARF_OFF_ISEL, isel, `ARF_RESP_OKAY);
			thr = 16'h8000;
			above = 0;
			below = 0;
			dir = d[0];
			wr(`ARF_OFF_CMP, {14'h0, thr, dir, 1'b0}, `ARF_RESP_OKAY);
			foreach (cseq[i]) res(5'h04, 1'b0, cseq[i], 1'b1);
			res(5'h05, 1'b0, d ? 16'hF000 : 16'h0100, 1'b1);
			isel = 32'h0000_0004;
		end
		rd(12'h020, `ARF_ZERO, `ARF_RESP_SLVERR);
		wr(`ARF_OFF_RES, 32'hFFFF_FFFF, `ARF_RESP_SLVERR);
		results();
	end
endmodule
bind arf_top arf_chk #(.NCH(NCH)) u_arf_chk (.aclk(aclk),
	.aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.conv_done(conv_done), .conv_chan(conv_chan),
	.conv_start(conv_start), .rate_code(rate_code),
	.buffer_bypass_switches(buffer_bypass_switches),
	.lv_irq0(lv_irq0), .lv_irq1(lv_irq1));
`default_nettype wire
